// ===== bench/host_event_alert_logic_sva.sv
`timescale 1ns/1ns
module host_event_alert_logic_sva (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  // watched ports
  input wire logic [7:0] events_a_in,
  input wire logic [5:0] events_b_in,
  input wire event_alert_pkg::wb_req_t wb_req_in,
  input wire event_alert_pkg::wb_rsp_t wb_rsp_out,
  input wire logic host_alert_n_out
);
  wire logic ack = wb_rsp_out.ack;
  wire logic req = wb_req_in.cyc && wb_req_in.stb;
  wire logic al = host_alert_n_out;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);
  property p_ack; req && !ack |=> ack; endproperty
  a_ack: assert property (p_ack) else $error("no ack");
  property p_pulse; ack |=> !ack; endproperty
  a_pulse: assert property (p_pulse) else $error("ack too long");
  property p_cause; $rose(ack) |-> $past(req); endproperty
  a_cause: assert property (p_cause) else $error("ack without request");
  property p_hi; ack |-> wb_rsp_out.dat[31:8] == 24'h00_0000; endproperty
  a_hi: assert property (p_hi) else $error("upper data bits set");
  property p_rsv; ack && !wb_req_in.we && wb_req_in.adr == event_alert_pkg::OFF_PEEK_B |-> !wb_rsp_out.dat[1];
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved flag set");
  property p_fall; $fell(al) |-> $past(|events_a_in, 2) || $past(|events_b_in, 2) || $past(ack); endproperty
  a_fall: assert property (p_fall) else $error("alert without cause");
  property p_rise; $rose(al) |-> $past(ack); endproperty
  a_rise: assert property (p_rise) else $error("alert released without access");
  property p_hold; !al && !ack |=> !al; endproperty
  a_hold: assert property (p_hold) else $error("alert dropped early");
endmodule : host_event_alert_logic_sva
bind host_event_alert_logic host_event_alert_logic_sva i_sva (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
  .events_a_in(events_a_in), .events_b_in(events_b_in), .wb_req_in(wb_req_in), .wb_rsp_out(wb_rsp_out),
  .host_alert_n_out(host_alert_n_out));

// ===== bench/host_model.sv
`timescale 1ns/1ns
module host_model (
  // clock
  input wire logic ref_clk_in,
  // bus
  output event_alert_pkg::wb_req_t req_out,
  input wire event_alert_pkg::wb_rsp_t rsp_in
);
  initial req_out = '0;
  // one classic cycle, entered just after a rising edge
  task xfer(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    req_out <= {1'b1, 1'b1, w, a, 4'h1, 24'h00_0000, d};
    do @(posedge ref_clk_in); while (rsp_in.ack !== 1'b1);
    q = rsp_in.dat[7:0];
    // released adr, sel and dat lines show the inverse, never the last value; cyc, stb and we drop to zero
    req_out <= {3'h0, ~req_out[43:0]};
    @(posedge ref_clk_in);
  endtask : xfer
endmodule : host_model

// ===== bench/tb.sv
`timescale 1ns/1ns
module tb;
  logic clk;
  logic rst;
  logic alert_n;
  logic [7:0] ea;
  logic [7:0] q;
  logic [5:0] eb;
  event_alert_pkg::wb_req_t req;
  event_alert_pkg::wb_rsp_t rsp;
  int fails = 0;
  int n_tests = 0;
  int cnt = 0;
  host_event_alert_logic i_dut (.ref_clk_in(clk), .sys_rst_in(rst), .events_a_in(ea), .events_b_in(eb),
    .wb_req_in(req), .wb_rsp_out(rsp), .host_alert_n_out(alert_n));
  host_model i_host (.ref_clk_in(clk), .req_out(req), .rsp_in(rsp));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task rd(input logic [7:0] a, input logic [7:0] e);
    i_host.xfer(1'b0, a, 8'h00, q);
    chk(q, e);
  endtask : rd
  task wr(input logic [7:0] a, input logic [7:0] d);
    i_host.xfer(1'b1, a, d, q);
  endtask : wr
  task ev(input logic [7:0] a, input logic [5:0] b);
    ea <= a;
    eb <= b;
    @(posedge clk);
    ea <= 8'h00;
    eb <= 6'h00;
    repeat (2) @(posedge clk);
  endtask : ev
  task t_reset;
    chk(8'(alert_n), 8'h01);
    rd(event_alert_pkg::OFF_MASK_A, 8'hff);
    rd(event_alert_pkg::OFF_MASK_B, 8'h3d);
    rd(event_alert_pkg::OFF_PEEK_A, 8'h00);
    rd(8'h20, 8'h00);
    $display("reset test done");
  endtask : t_reset
  task t_set;
    ev(8'hff, 6'h3f);
    chk(8'(alert_n), 8'h00);
    rd(event_alert_pkg::OFF_PEEK_A, 8'hff);
    rd(event_alert_pkg::OFF_PEEK_B, 8'h3d);
    rd(event_alert_pkg::OFF_STATUS_A, 8'hff);
    chk(8'(alert_n), 8'h00);
    rd(event_alert_pkg::OFF_PEEK_A, 8'h00);
    rd(event_alert_pkg::OFF_STATUS_B, 8'h3d);
    chk(8'(alert_n), 8'h01);
    $display("event test done");
  endtask : t_set
  task t_mask;
    wr(event_alert_pkg::OFF_MASK_A, 8'h00);
    ev(8'h81, 6'h00);
    chk(8'(alert_n), 8'h01);
    wr(event_alert_pkg::OFF_PEEK_A, 8'h00);
    rd(event_alert_pkg::OFF_PEEK_A, 8'h81);
    rd(event_alert_pkg::OFF_PEEK_A, 8'h81);
    wr(event_alert_pkg::OFF_MASK_A, 8'hff);
    chk(8'(alert_n), 8'h00);
    rd(event_alert_pkg::OFF_STATUS_A, 8'h81);
    chk(8'(alert_n), 8'h01);
    $display("mask test done");
  endtask : t_mask
  // an event landing on the clearing read survives it
  task t_race;
    ea <= 8'h04;
    fork
      rd(event_alert_pkg::OFF_STATUS_A, 8'h00);
      begin
        @(posedge clk);
        ea <= 8'h00;
      end
    join
    chk(8'(alert_n), 8'h00);
    rd(event_alert_pkg::OFF_PEEK_A, 8'h04);
    rd(event_alert_pkg::OFF_STATUS_A, 8'h04);
    chk(8'(alert_n), 8'h01);
    $display("race test done");
  endtask : t_race
  // bank b masking, then a reset in mid-run restores the defaults
  task t_rerun;
    wr(event_alert_pkg::OFF_MASK_B, 8'h00);
    rd(event_alert_pkg::OFF_MASK_B, 8'h00);
    ev(8'h10, 6'h10);
    chk(8'(alert_n), 8'h00);
    rd(event_alert_pkg::OFF_STATUS_A, 8'h10);
    chk(8'(alert_n), 8'h01);
    rd(event_alert_pkg::OFF_PEEK_B, 8'h10);
    ev(8'h20, 6'h00);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk(8'(alert_n), 8'h01);
    rd(event_alert_pkg::OFF_MASK_B, 8'h3d);
    rd(event_alert_pkg::OFF_PEEK_A, 8'h00);
    rd(event_alert_pkg::OFF_PEEK_B, 8'h00);
    $display("reset rerun test done");
  endtask : t_rerun
  task stop_test;
    $display("mismatches %0d of %0d checks", fails, n_tests);
    if (fails == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : stop_test
  always @(posedge clk) begin
    cnt <= cnt + 1;
    if (cnt == 2000) begin
      fails++;
      stop_test;
    end
  end
  initial begin
    rst = 1'b1;
    ea = 8'h00;
    eb = 6'h00;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset;
    t_set;
    t_mask;
    t_race;
    t_rerun;
    stop_test;
  end
endmodule : tb

// ===== design/event_alert_pkg.sv
package event_alert_pkg;
  // register byte offsets on the wishbone bus (one aligned word each)
  localparam logic [7:0] OFF_STATUS_A = 8'h00;
  localparam logic [7:0] OFF_MASK_A = 8'h04;
  localparam logic [7:0] OFF_PEEK_A = 8'h08;
  localparam logic [7:0] OFF_STATUS_B = 8'h0c;
  localparam logic [7:0] OFF_MASK_B = 8'h10;
  localparam logic [7:0] OFF_PEEK_B = 8'h14;
  localparam int BANK_W = 8;
  localparam int SRC_A = 8;
  localparam int SRC_B = 6;
  localparam int SRC_TOTAL = 14;
  // bank a bit positions
  localparam int A_RX_PKT = 0;
  localparam int A_RX_FULL = 1;
  localparam int A_TX_DONE = 2;
  localparam int A_FLASH_DONE = 3;
  localparam int A_OSC_READY = 4;
  localparam int A_SELF_INIT = 5;
  localparam int A_RX_EMPTY = 6;
  localparam int A_END_PKT = 7;
  // bank b bit positions
  localparam int B_ANEG_DONE = 0;
  localparam int B_RESERVED = 1;
  localparam int B_ANEG_FAIL = 2;
  localparam int B_JABBER = 3;
  localparam int B_LINK_CHG = 4;
  localparam int B_WAKE = 5;
  // implemented bits of each bank
  localparam logic [7:0] IMPL_A = 8'hff;
  localparam logic [7:0] IMPL_B = 8'h3d;
  localparam logic [7:0] RST_STATUS = 8'h00;
  localparam logic [7:0] RST_MASK = 8'hff;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } wb_rsp_t;
endpackage : event_alert_pkg

// ===== design/event_bank.sv
`timescale 1ns/1ns
// one bank of sticky pending flags with its enable mask
module event_bank #(
  parameter int WIDTH = 8,
  parameter logic [7:0] IMPL = 8'hff
) (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  // event pulses
  input wire logic [WIDTH-1:0] event_in,
  // software side
  input wire logic clear_in,
  input wire logic mask_we_in,
  input wire logic [WIDTH-1:0] mask_wdata_in,
  // state
  output logic [WIDTH-1:0] status_out,
  output logic [WIDTH-1:0] mask_out,
  output logic pending_out
);
  logic [WIDTH-1:0] status_r;
  logic [WIDTH-1:0] status_nxt;
  logic [WIDTH-1:0] mask_r;
  logic [WIDTH-1:0] mask_nxt;

  initial begin
    if (WIDTH != 8) $error("event_bank supports width 8 only");
  end

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_flag
      always_comb begin
        // a new event wins over a clearing read in the same cycle
        status_nxt[i] = IMPL[i] & (event_in[i] | (status_r[i] & ~clear_in)); // R10 R4
        mask_nxt[i] = mask_we_in ? (mask_wdata_in[i] & IMPL[i]) : mask_r[i]; // R5
      end
    end
  endgenerate

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      status_r <= event_alert_pkg::RST_STATUS;
      mask_r <= event_alert_pkg::RST_MASK & IMPL;
    end else begin
      status_r <= status_nxt;
      mask_r <= mask_nxt;
    end
  end

  assign status_out = status_r;
  assign mask_out = mask_r;
  assign pending_out = |(status_r & mask_r); // R2 R3
endmodule : event_bank

// ===== design/event_wb_slave.sv
`timescale 1ns/1ns
// classic wishbone slave: ack one cycle after the request, for one cycle
module event_wb_slave (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  // bus
  input wire event_alert_pkg::wb_req_t req_in,
  output event_alert_pkg::wb_rsp_t rsp_out,
  // register read data supplied by decode
  input wire logic [31:0] rdata_in,
  // one-cycle access strobe, at the edge that returns ack
  output logic access_out
);
  logic ack_r;
  logic ack_nxt;
  logic [31:0] dat_r;
  logic [31:0] dat_nxt;

  always_comb begin
    ack_nxt = req_in.cyc & req_in.stb & ~ack_r;
    dat_nxt = ack_nxt ? rdata_in : dat_r;
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      ack_r <= 1'b0;
      dat_r <= event_alert_pkg::RD_ZERO;
    end else begin
      ack_r <= ack_nxt;
      dat_r <= dat_nxt;
    end
  end

  assign access_out = ack_nxt;
  assign rsp_out.ack = ack_r;
  assign rsp_out.dat = dat_r;
endmodule : event_wb_slave

// ===== design/host_event_alert_logic.sv
// Design decisions made here: register access over Wishbone and the register addresses.
`timescale 1ns/1ns
// Function
// R1: thirteen event sources can each raise a host interrupt request.
// R2: an enabled event sets its pending flag and drives the alert low.
// R3: alert stays low while any enabled pending flag remains set.
// R4: reading a clearing status register returns flags and clears them.
// R5: clearing an enable bit stops that source from interrupting.
// R6: peek registers return pending flags without clearing them.
// R7: a host may poll status registers instead of watching the alert.
// R8: bank a bits: end pkt, rx empty, self init, osc, flash, tx, full, rx.
// R9: bank b bits: wake, link change, jabber, aneg fail, reserved, aneg done.
// R10: a pending flag stays set until a clearing read.
// R11: alert is registered inverted or of masked flags, high after reset.
module host_event_alert_logic (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  // event pulses from the controller units, same clock
  input wire logic [event_alert_pkg::SRC_A-1:0] events_a_in,
  input wire logic [event_alert_pkg::SRC_B-1:0] events_b_in,
  // register bus
  input wire event_alert_pkg::wb_req_t wb_req_in,
  output event_alert_pkg::wb_rsp_t wb_rsp_out,
  // host alert, active low
  output logic host_alert_n_out
);
  logic access;
  logic [31:0] rdata;
  logic clr_a;
  logic clr_b;
  logic mwe_a;
  logic mwe_b;
  logic [7:0] ev_a;
  logic [7:0] ev_b;
  logic [7:0] status_a;
  logic [7:0] status_b;
  logic [7:0] mask_a;
  logic [7:0] mask_b;
  logic pend_a;
  logic pend_b;
  logic alert_n_r;
  logic alert_n_nxt;
  logic wr_lane0;

  // bank a takes all eight sources in place; bank b sources sit at their bit positions
  always_comb begin
    ev_a = events_a_in; // R1 R8
    ev_b = {2'b00, events_b_in} & event_alert_pkg::IMPL_B; // R1 R9
  end

  event_wb_slave u_bus (
    .ref_clk_in(ref_clk_in),
    .sys_rst_in(sys_rst_in),
    .req_in(wb_req_in),
    .rsp_out(wb_rsp_out),
    .rdata_in(rdata),
    .access_out(access)
  );

  // address decode and side effects of an access
  always_comb begin
    rdata = event_alert_pkg::RD_ZERO;
    clr_a = 1'b0;
    clr_b = 1'b0;
    mwe_a = 1'b0;
    mwe_b = 1'b0;
    wr_lane0 = access & wb_req_in.we & wb_req_in.sel[0];
    if (wb_req_in.adr == event_alert_pkg::OFF_STATUS_A) begin
      rdata = {24'h00_0000, status_a};
      clr_a = access & ~wb_req_in.we; // R4
    end else if (wb_req_in.adr == event_alert_pkg::OFF_MASK_A) begin
      rdata = {24'h00_0000, mask_a};
      mwe_a = wr_lane0; // R5
    end else if (wb_req_in.adr == event_alert_pkg::OFF_PEEK_A) begin
      rdata = {24'h00_0000, status_a}; // R6
    end else if (wb_req_in.adr == event_alert_pkg::OFF_STATUS_B) begin
      rdata = {24'h00_0000, status_b};
      clr_b = access & ~wb_req_in.we; // R4
    end else if (wb_req_in.adr == event_alert_pkg::OFF_MASK_B) begin
      rdata = {24'h00_0000, mask_b};
      mwe_b = wr_lane0; // R5
    end else if (wb_req_in.adr == event_alert_pkg::OFF_PEEK_B) begin
      rdata = {24'h00_0000, status_b}; // R6
    end else begin
      rdata = event_alert_pkg::RD_ZERO;
    end
  end

  event_bank #(
    .WIDTH(event_alert_pkg::BANK_W),
    .IMPL(event_alert_pkg::IMPL_A)
  ) u_bank_a (
    .ref_clk_in(ref_clk_in),
    .sys_rst_in(sys_rst_in),
    .event_in(ev_a),
    .clear_in(clr_a),
    .mask_we_in(mwe_a),
    .mask_wdata_in(wb_req_in.dat[7:0]),
    .status_out(status_a),
    .mask_out(mask_a),
    .pending_out(pend_a)
  );

  event_bank #(
    .WIDTH(event_alert_pkg::BANK_W),
    .IMPL(event_alert_pkg::IMPL_B)
  ) u_bank_b (
    .ref_clk_in(ref_clk_in),
    .sys_rst_in(sys_rst_in),
    .event_in(ev_b),
    .clear_in(clr_b),
    .mask_we_in(mwe_b),
    .mask_wdata_in(wb_req_in.dat[7:0]),
    .status_out(status_b),
    .mask_out(mask_b),
    .pending_out(pend_b)
  );

  always_comb begin
    alert_n_nxt = ~(pend_a | pend_b); // R11 R2 R3
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      alert_n_r <= 1'b1; // R11
    end else begin
      alert_n_r <= alert_n_nxt;
    end
  end

  assign host_alert_n_out = alert_n_r;
endmodule : host_event_alert_logic
